// [csl_alert_latch.sv]
// Sticky alert latch bank with enable gating and write-zero clear.
// Assumes set, enable and clear come from core_clk logic.
`timescale 1ns/1ns
module csl_alert_latch #(
	parameter int W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set_cond,
	input  wire logic [W-1:0] enable,
	input  wire logic         clr_wr,
	input  wire logic [W-1:0] clr_data,
	output logic      [W-1:0] latched
);
	logic [W-1:0] clr_mask;

	// Bits written as zero are cleared, ones keep their value
	assign clr_mask = clr_wr ? ~clr_data : '0;

	// Set wins over clear; a dropped enable clears the bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			latched <= '0;
		end else begin
			latched <= ((latched & ~clr_mask) | set_cond) & enable;
		end
	end

	a_set_enabled: assert property (@(posedge core_clk) disable iff (rst)
		(|(set_cond & enable)) |=> ((latched & $past(set_cond & enable)) == $past(set_cond & enable)))
		else $error("enabled alert not latched");
	a_never_unenabled: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> ((latched & ~$past(enable)) == '0))
		else $error("alert held without enable");
	a_clear_written: assert property (@(posedge core_clk) disable iff (rst)
		clr_wr |=> ((latched & ~$past(clr_data) & ~$past(set_cond)) == '0))
		else $error("written zero bit not cleared");
	a_sticky_hold: assert property (@(posedge core_clk) disable iff (rst)
		(!clr_wr) |=> ((latched & $past(latched & enable)) == $past(latched & enable)))
		else $error("alert dropped without clear");
endmodule : csl_alert_latch

// [csl_host_model.sv]
// Serial host model that reads and writes the status block registers.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module csl_host_model (
	input  wire logic core_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_low
);
	// Bus idles released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Half bit period, twice the minimum phase
	task automatic hp;
		repeat (8) @(negedge core_clk);
	endtask : hp
	// Start or repeated start; data is released while the clock is low, then pulled low while the clock is high
	task automatic start;
		sda_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b1;
		hp();
		scl = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask : start
	// Stop leaves the bus idle
	task automatic stop;
		sda_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b0;
		hp();
	endtask : stop
	// One bit slot; the level is taken just before the clock falls
	task automatic slot(input logic drive_low, output logic seen);
		sda_low = drive_low;
		hp();
		scl = 1'b1;
		hp();
		seen = sda_wire;
		scl = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask : slot
	// Byte out, MSB first; ack is one when the device pulls data low
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(!b[i], s);
		end
		slot(1'b0, s);
		ack = !s;
	endtask : put
	// Byte in, MSB first, then our ack or nack
	task automatic get(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b0, s);
			b[i] = s;
		end
		slot(ack, s);
	endtask : get
	// Word write, low byte first
	task automatic write_word(input logic [6:0] dev, input logic [7:0] cmd,
		input logic [15:0] d, output logic [3:0] acks);
		start();
		put({dev, 1'b0}, acks[3]);
		put(cmd, acks[2]);
		put(d[7:0], acks[1]);
		put(d[15:8], acks[0]);
		stop();
	endtask : write_word
	// Word read through a repeated start, nack on the last byte
	task automatic read_word(input logic [6:0] dev, input logic [7:0] cmd,
		output logic [15:0] d);
		logic a;
		start();
		put({dev, 1'b0}, a);
		put(cmd, a);
		start();
		put({dev, 1'b1}, a);
		get(1'b1, d[7:0]);
		get(1'b0, d[15:8]);
		stop();
	endtask : read_word
endmodule : csl_host_model

// [csl_pkg.sv]
// Constants for the charger state and alert latch block.
// Assumes a single core clock domain; the serial port is sampled inside.
package csl_pkg;
	// Register command codes
	localparam logic [7:0]  CMD_CHARGER_STATE = 8'h34;
	localparam logic [7:0]  CMD_CHARGE_STATUS = 8'h35;
	localparam logic [7:0]  CMD_LIMIT_ALERTS  = 8'h36;
	localparam logic [7:0]  CMD_STATE_ALERTS  = 8'h37;
	// Widths
	localparam int          STATE_W  = 13;
	localparam int          STATUS_W = 6;
	localparam int          LIMIT_W  = 16;
	// Charger state codes, one hot
	localparam logic [12:0] ST_DETECT_FAILED = 13'h1000;
	localparam logic [12:0] ST_BAT_DETECTION = 13'h0800;
	localparam logic [12:0] ST_EQUALIZE      = 13'h0400;
	localparam logic [12:0] ST_ABSORB        = 13'h0200;
	localparam logic [12:0] ST_SUSPENDED     = 13'h0100;
	localparam logic [12:0] ST_BULK_REG      = 13'h0040;
	localparam logic [12:0] ST_BAT_MISSING   = 13'h0002;
	localparam logic [12:0] ST_BAT_SHORT     = 13'h0001;
	localparam logic [12:0] STATE_RESET      = ST_SUSPENDED;
	localparam logic [12:0] STATE_USED_MASK  = 13'h1f43;
	// Charge status code for input current limit regulation
	localparam logic [5:0]  CS_INPUT_ILIM    = 6'h20;
	localparam logic [5:0]  STATUS_RESET     = 6'h00;
	// Limit alert bit positions
	localparam int          LA_TELEM_VALID = 15;
	localparam int          LA_RES_DONE    = 14;
	localparam int          LA_VBAT_LO     = 11;
	localparam int          LA_VBAT_HI     = 10;
	localparam int          LA_VIN_LO      = 9;
	localparam int          LA_VIN_HI      = 8;
	localparam int          LA_VOUT_LO     = 7;
	localparam int          LA_VOUT_HI     = 6;
	localparam int          LA_IIN_HI      = 5;
	localparam int          LA_IBAT_LO     = 4;
	localparam int          LA_DIE_HI      = 3;
	localparam int          LA_RES_HI      = 2;
	localparam int          LA_THERM_HI    = 1;
	localparam int          LA_THERM_LO    = 0;
	// Serial port address, value arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h2a;
	localparam logic [2:0]  LAST_BIT         = 3'h7;
	// Serial port byte phases
	typedef enum logic [2:0] {
		SP_IDLE, SP_ADDR, SP_CMD, SP_WLO, SP_WHI, SP_RLO, SP_RHI
	} csl_phase_t;
endpackage : csl_pkg

// [csl_status_regs.sv]
// Charger state and alert latch register block behind the serial port.
// Assumes the charger core, comparators and enable registers run on core_clk;
// the serial clock and data pins are asynchronous and sampled here.
`timescale 1ns/1ns
// Notes on behaviour
// - State register is 13 bits, one hot, read only, resets to suspended.
// - State codes: 4096,2048,1024,512,256,64,2,1 for the documented states.
// - Six bit one hot charge status, zero unless charging; value 32 is input limit.
// - Enabled limit alerts latch into 16 bits, sticky until cleared, reset zero.
// - Host clears a bit by writing it 0, others 1; only zero bits clear.
// - Clearing an enable bit clears its latched alert.
// - Bit 15 sets when telemetry warm-up ends and readings are valid.
// - Bit 14 sets when a resistance measurement result is stored.
// - Bit 11 on battery voltage below low limit, bit 10 above high.
// - Bit 9 on input voltage below low limit, bit 8 above high.
// - Bit 7 on output voltage below low limit, bit 6 above high.
// - Bit 5 on input current above its high limit.
// - Bit 4 on battery current below its low limit.
// - Bit 3 on die temperature above its high limit.
// - Bit 2 on resistance result above its high limit.
// - Bit 1 on thermistor voltage above high limit, bit 0 below low.
// - Enabled charger states latch into 13 sticky bits, reset zero, same clear.
// - State alert bit 12 on detection failed, bit 11 during detection.
// - State alert bits 10,9,8,6,1,0 for equalize, absorb, suspend, bulk, missing, short.
module csl_status_regs #(
	parameter logic [6:0] DEV_ADDR = csl_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [12:0] core_state,
	input  wire logic [5:0]  core_status,
	input  wire logic [15:0] limit_alert_enable,
	input  wire logic [12:0] state_alert_enable,
	input  wire logic        telem_ready,
	input  wire logic        res_done,
	input  wire logic        vbat_lo,
	input  wire logic        vbat_hi,
	input  wire logic        vin_lo,
	input  wire logic        vin_hi,
	input  wire logic        vout_lo,
	input  wire logic        vout_hi,
	input  wire logic        iin_hi,
	input  wire logic        ibat_lo,
	input  wire logic        die_temp_hi,
	input  wire logic        res_hi,
	input  wire logic        therm_hi,
	input  wire logic        therm_lo,
	output logic [12:0]      charger_state_indicator,
	output logic [5:0]       charge_status_indicator,
	output logic [15:0]      limit_alert_latches,
	output logic [12:0]      state_alert_latches
);
	// True in the states where the charger is delivering current
	function automatic logic is_charging(input logic [12:0] st);
		is_charging = (st == csl_pkg::ST_EQUALIZE) || (st == csl_pkg::ST_ABSORB)
			|| (st == csl_pkg::ST_BULK_REG);
	endfunction : is_charging

	// A code is accepted only if it is one of the defined one-hot states
	function automatic logic is_state_code(input logic [12:0] st);
		is_state_code = $onehot(st) && ((st & ~csl_pkg::STATE_USED_MASK) == '0);
	endfunction : is_state_code

	// Read data for a command code; unmapped codes read zero
	function automatic logic [15:0] reg_read(input logic [7:0] cmd,
		input logic [12:0] st, input logic [5:0] cs,
		input logic [15:0] la, input logic [12:0] sa);
		case (cmd)
			csl_pkg::CMD_CHARGER_STATE: reg_read = {3'h0, st};
			csl_pkg::CMD_CHARGE_STATUS: reg_read = {10'h000, cs};
			csl_pkg::CMD_LIMIT_ALERTS:  reg_read = la;
			csl_pkg::CMD_STATE_ALERTS:  reg_read = {3'h0, sa};
			default:                    reg_read = 16'h0000;
		endcase
	endfunction : reg_read

	logic [1:0]          pins_s;
	logic                scl_s;
	logic                sda_s;
	logic                scl_d;
	logic                sda_d;
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;
	csl_pkg::csl_phase_t phase;
	logic [2:0]          bit_cnt;
	logic                got8;
	logic                ack_phase;
	logic                rw_read;
	logic                master_nack;
	logic [7:0]          rx_shift;
	logic [7:0]          tx_shift;
	logic [7:0]          rd_hi;
	logic [7:0]          cmd_code;
	logic [7:0]          wr_lo;
	logic                wr_commit;
	logic [15:0]         wr_word;
	logic [12:0]         next_state;
	logic [15:0]         limit_set;
	logic [15:0]         rd_word;

	// Pin synchronisers
	csl_sync #(
		.W (2)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({scl_in, sda_in}),
		.sync_out (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Delayed copies of the synchronised pins for edge detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// Bus events
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	assign rd_word = reg_read(cmd_code, charger_state_indicator, charge_status_indicator,
		limit_alert_latches, state_alert_latches);

	// Open-drain data: only ever pulls low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Serial port byte engine: address, command, data word low byte first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase       <= csl_pkg::SP_IDLE;
			bit_cnt     <= 3'h0;
			got8        <= 1'b0;
			ack_phase   <= 1'b0;
			rw_read     <= 1'b0;
			master_nack <= 1'b0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			rd_hi       <= 8'h00;
			cmd_code    <= 8'h00;
			wr_lo       <= 8'h00;
			wr_commit   <= 1'b0;
			wr_word     <= 16'h0000;
			sda_oe      <= 1'b0;
		end else begin
			wr_commit <= 1'b0;
			if (bus_start) begin
				phase     <= csl_pkg::SP_ADDR;
				bit_cnt   <= 3'h0;
				got8      <= 1'b0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (bus_stop) begin
				phase  <= csl_pkg::SP_IDLE;
				sda_oe <= 1'b0;
			end else if (phase != csl_pkg::SP_IDLE && scl_rise) begin
				if (ack_phase) begin
					master_nack <= sda_s;
				end else begin
					rx_shift <= {rx_shift[6:0], sda_s};
					bit_cnt  <= bit_cnt + 3'h1;
					got8     <= (bit_cnt == csl_pkg::LAST_BIT);
				end
			end else if (phase != csl_pkg::SP_IDLE && scl_fall) begin
				if (got8) begin
					// Byte finished: acknowledge received bytes (the address only on a match), release after sent ones
					got8      <= 1'b0;
					ack_phase <= 1'b1;
					sda_oe    <= 1'b0;
					case (phase)
						csl_pkg::SP_ADDR: begin
							if (rx_shift[7:1] == DEV_ADDR) begin
								sda_oe  <= 1'b1;
								rw_read <= rx_shift[0];
							end else begin
								phase <= csl_pkg::SP_IDLE;
							end
						end
						csl_pkg::SP_CMD: begin
							cmd_code <= rx_shift;
							sda_oe   <= 1'b1;
						end
						csl_pkg::SP_WLO: begin
							wr_lo  <= rx_shift;
							sda_oe <= 1'b1;
						end
						csl_pkg::SP_WHI: begin
							wr_word   <= {rx_shift, wr_lo};
							wr_commit <= 1'b1;
							sda_oe    <= 1'b1;
						end
						default: begin
							sda_oe <= 1'b0;
						end
					endcase
				end else if (ack_phase) begin
					// Acknowledge slot over: move to the next byte
					ack_phase <= 1'b0;
					bit_cnt   <= 3'h0;
					sda_oe    <= 1'b0;
					case (phase)
						csl_pkg::SP_ADDR: begin
							if (rw_read) begin
								phase    <= csl_pkg::SP_RLO;
								tx_shift <= rd_word[7:0];
								rd_hi    <= rd_word[15:8];
								sda_oe   <= ~rd_word[7];
							end else begin
								phase <= csl_pkg::SP_CMD;
							end
						end
						csl_pkg::SP_CMD: phase <= csl_pkg::SP_WLO;
						csl_pkg::SP_WLO: phase <= csl_pkg::SP_WHI;
						csl_pkg::SP_RLO: begin
							if (master_nack) begin
								phase <= csl_pkg::SP_IDLE;
							end else begin
								phase    <= csl_pkg::SP_RHI;
								tx_shift <= rd_hi;
								sda_oe   <= ~rd_hi[7];
							end
						end
						default: phase <= csl_pkg::SP_IDLE;
					endcase
				end else if (phase == csl_pkg::SP_RLO || phase == csl_pkg::SP_RHI) begin
					// Shift out the next data bit, most significant first
					tx_shift <= {tx_shift[6:0], 1'b0};
					sda_oe   <= ~tx_shift[6];
				end
			end
		end
	end

	// Accept only valid one-hot state codes from the core
	assign next_state = is_state_code(core_state) ? core_state : charger_state_indicator;

	// Charger state indicator
	always_ff @(posedge core_clk) begin
		if (rst) begin
			charger_state_indicator <= csl_pkg::STATE_RESET;
		end else begin
			charger_state_indicator <= next_state;
		end
	end

	// Charge status shows only while charging and only as a single bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			charge_status_indicator <= csl_pkg::STATUS_RESET;
		end else if (is_charging(next_state) && $onehot(core_status)) begin
			charge_status_indicator <= core_status;
		end else begin
			charge_status_indicator <= csl_pkg::STATUS_RESET;
		end
	end

	// Limit alert trigger vector; unused positions never set
	always_comb begin
		limit_set                          = 16'h0000;
		limit_set[csl_pkg::LA_TELEM_VALID] = telem_ready;
		limit_set[csl_pkg::LA_RES_DONE]    = res_done;
		limit_set[csl_pkg::LA_VBAT_LO]     = vbat_lo;
		limit_set[csl_pkg::LA_VBAT_HI]     = vbat_hi;
		limit_set[csl_pkg::LA_VIN_LO]      = vin_lo;
		limit_set[csl_pkg::LA_VIN_HI]      = vin_hi;
		limit_set[csl_pkg::LA_VOUT_LO]     = vout_lo;
		limit_set[csl_pkg::LA_VOUT_HI]     = vout_hi;
		limit_set[csl_pkg::LA_IIN_HI]      = iin_hi;
		limit_set[csl_pkg::LA_IBAT_LO]     = ibat_lo;
		limit_set[csl_pkg::LA_DIE_HI]      = die_temp_hi;
		limit_set[csl_pkg::LA_RES_HI]      = res_hi;
		limit_set[csl_pkg::LA_THERM_HI]    = therm_hi;
		limit_set[csl_pkg::LA_THERM_LO]    = therm_lo;
	end

	// Limit alert latches, cleared by a word write to their command code
	csl_alert_latch #(
		.W (csl_pkg::LIMIT_W)
	) u_limit (
		.core_clk (core_clk),
		.rst      (rst),
		.set_cond (limit_set),
		.enable   (limit_alert_enable),
		.clr_wr   (wr_commit && cmd_code == csl_pkg::CMD_LIMIT_ALERTS),
		.clr_data (wr_word),
		.latched  (limit_alert_latches)
	);

	// State alert latches are set by the present state bit by bit and stay set until cleared
	csl_alert_latch #(
		.W (csl_pkg::STATE_W)
	) u_state (
		.core_clk (core_clk),
		.rst      (rst),
		.set_cond (charger_state_indicator),
		.enable   (state_alert_enable),
		.clr_wr   (wr_commit && cmd_code == csl_pkg::CMD_STATE_ALERTS),
		.clr_data (wr_word[12:0]),
		.latched  (state_alert_latches)
	);

	a_state_onehot: assert property (@(posedge core_clk) disable iff (rst)
		$onehot(charger_state_indicator))
		else $error("charger state not one hot");
	a_state_reset: assert property (@(posedge core_clk)
		rst |=> charger_state_indicator == csl_pkg::STATE_RESET)
		else $error("charger state reset value wrong");
	a_status_idle: assert property (@(posedge core_clk) disable iff (rst)
		!is_charging(charger_state_indicator) |-> charge_status_indicator == csl_pkg::STATUS_RESET)
		else $error("charge status nonzero while not charging");
	a_state_alert: assert property (@(posedge core_clk) disable iff (rst)
		(state_alert_enable[12] && charger_state_indicator == csl_pkg::ST_DETECT_FAILED)
		|=> state_alert_latches[12])
		else $error("detection failed alert missed");
	a_telem_alert: assert property (@(posedge core_clk) disable iff (rst)
		(telem_ready && limit_alert_enable[15]) |=> limit_alert_latches[15])
		else $error("telemetry alert missed");
	a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
		limit_alert_latches[13:12] == 2'h0)
		else $error("unused limit alert bits set");
endmodule : csl_status_regs

// [csl_status_regs_bench.sv]
// Self-checking bench for the charger state and alert latch block.
// Assumes the host model reaches the registers over the serial pins.
`timescale 1ns/1ns
module csl_status_regs_bench;
	localparam logic [7:0] A_ST = csl_pkg::CMD_CHARGER_STATE;
	localparam logic [7:0] A_CS = csl_pkg::CMD_CHARGE_STATUS;
	localparam logic [7:0] A_LA = csl_pkg::CMD_LIMIT_ALERTS;
	localparam logic [7:0] A_SA = csl_pkg::CMD_STATE_ALERTS;
	logic        core_clk, rst, scl, sda_low, sda_wire, sda_out, sda_oe, chg;
	logic [12:0] core_state, state_alert_enable, ind_st, sa, exp13;
	logic [12:0] codes [8];
	logic [5:0]  core_status, ind_cs;
	logic [15:0] limit_alert_enable, trig, la, rdv, exp16;
	logic [3:0]  acks;
	int          bad_count, num_checks, cycles;
	// Open-drain data wire with pull-up
	assign sda_wire = !sda_low && (sda_oe ? sda_out : 1'b1);
	csl_status_regs u_dut (
		.core_clk                (core_clk),
		.rst                     (rst),
		.scl_in                  (scl),
		.sda_in                  (sda_wire),
		.sda_out                 (sda_out),
		.sda_oe                  (sda_oe),
		.core_state              (core_state),
		.core_status             (core_status),
		.limit_alert_enable      (limit_alert_enable),
		.state_alert_enable      (state_alert_enable),
		.telem_ready             (trig[15]),
		.res_done                (trig[14]),
		.vbat_lo                 (trig[11]),
		.vbat_hi                 (trig[10]),
		.vin_lo                  (trig[9]),
		.vin_hi                  (trig[8]),
		.vout_lo                 (trig[7]),
		.vout_hi                 (trig[6]),
		.iin_hi                  (trig[5]),
		.ibat_lo                 (trig[4]),
		.die_temp_hi             (trig[3]),
		.res_hi                  (trig[2]),
		.therm_hi                (trig[1]),
		.therm_lo                (trig[0]),
		.charger_state_indicator (ind_st),
		.charge_status_indicator (ind_cs),
		.limit_alert_latches     (la),
		.state_alert_latches     (sa)
	);
	csl_host_model u_host (
		.core_clk (core_clk),
		.sda_wire (sda_wire),
		.scl      (scl),
		.sda_low  (sda_low)
	);
	// Clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Register read and write over the serial port
	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		u_host.read_word(csl_pkg::DEV_ADDR_DEFAULT, cmd, rdv);
		check($sformatf("read %h", cmd), rdv, exp);
	endtask : rd
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		u_host.write_word(csl_pkg::DEV_ADDR_DEFAULT, cmd, d, acks);
		check("write acks", {12'h000, acks}, 16'h000f);
	endtask : wr
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		codes = '{csl_pkg::ST_DETECT_FAILED, csl_pkg::ST_BAT_DETECTION, csl_pkg::ST_EQUALIZE,
			csl_pkg::ST_ABSORB, csl_pkg::ST_BULK_REG, csl_pkg::ST_BAT_MISSING,
			csl_pkg::ST_BAT_SHORT, csl_pkg::ST_SUSPENDED};
		rst = 1'b1;
		core_state = csl_pkg::ST_SUSPENDED;
		core_status = csl_pkg::CS_INPUT_ILIM;
		limit_alert_enable = 16'h0000;
		state_alert_enable = 13'h0000;
		trig = 16'h0000;
		cyc(5);
		rst = 1'b0;
		cyc(4);
		check("state ind", {3'h0, ind_st}, 16'h0100);
		rd(A_ST, 16'h0100);
		rd(A_CS, 16'h0000);
		rd(A_LA, 16'h0000);
		rd(A_SA, 16'h0000);
		$display("test reset done");
		// Every state code; status only reported while charging
		state_alert_enable = 13'h1fff;
		exp13 = 13'h0100;
		for (int i = 0; i < 8; i++) begin
			core_state = codes[i];
			cyc(3);
			exp13 = exp13 | codes[i];
			chg = codes[i] inside {csl_pkg::ST_EQUALIZE, csl_pkg::ST_ABSORB, csl_pkg::ST_BULK_REG};
			check("state ind", {3'h0, ind_st}, {3'h0, codes[i]});
			check("state alerts", {3'h0, sa}, {3'h0, exp13});
			check("status ind", {10'h000, ind_cs}, chg ? 16'h0020 : 16'h0000);
		end
		core_state = 13'h0003;
		cyc(3);
		check("state ind", {3'h0, ind_st}, 16'h0100);
		rd(A_SA, 16'h1f43);
		wr(A_SA, 16'hefff);
		wr(A_SA, 16'hfeff);
		rd(A_SA, 16'h0f43);
		state_alert_enable = 13'h1ffe;
		cyc(2);
		check("state alerts", {3'h0, sa}, 16'h0f42);
		core_state = csl_pkg::ST_BULK_REG;
		rd(A_CS, 16'h0020);
		// A status code with two bits set is not shown
		core_status = 6'h21;
		cyc(2);
		check("status ind", {10'h000, ind_cs}, 16'h0000);
		core_status = csl_pkg::CS_INPUT_ILIM;
		core_state = csl_pkg::ST_SUSPENDED;
		$display("test states done");
		// Each limit trigger pulsed once; earlier bits must stay set
		limit_alert_enable = 16'hffff;
		exp16 = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (i == 12 || i == 13)
				continue;
			trig[i] = 1'b1;
			cyc(1);
			trig[i] = 1'b0;
			cyc(2);
			exp16[i] = 1'b1;
			check("limit alerts", la, exp16);
		end
		rd(A_LA, 16'hcfff);
		wr(A_LA, 16'hfbff);
		rd(A_LA, 16'hcbff);
		trig[11] = 1'b1;
		wr(A_LA, 16'hf7ff);
		rd(A_LA, 16'hcbff);
		trig[11] = 1'b0;
		wr(A_LA, 16'hf7ff);
		rd(A_LA, 16'hc3ff);
		limit_alert_enable[3] = 1'b0;
		trig[3] = 1'b1;
		cyc(3);
		check("limit alerts", la, 16'hc3f7);
		limit_alert_enable[3] = 1'b1;
		trig[3] = 1'b0;
		cyc(3);
		check("limit alerts", la, 16'hc3f7);
		$display("test limits done");
		// Read-only write, unmapped read, foreign address
		wr(A_ST, 16'h0001);
		rd(A_ST, 16'h0100);
		rd(8'h50, 16'h0000);
		u_host.write_word(7'h2b, A_LA, 16'h0000, acks);
		check("foreign acks", {12'h000, acks}, 16'h0000);
		check("limit alerts", la, 16'hc3f7);
		$display("test refusals done");
		// Reset in mid-run clears the latches; suspended re-latches at once
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(4);
		check("state ind", {3'h0, ind_st}, 16'h0100);
		check("limit alerts", la, 16'h0000);
		check("state alerts", {3'h0, sa}, 16'h0100);
		rd(A_LA, 16'h0000);
		$display("test mid reset done");
		tally_and_finish();
	end
endmodule : csl_status_regs_bench

// [csl_sync.sv]
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module csl_sync #(
	parameter int W = 2
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage; idle bus level is high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta     <= '1;
			sync_out <= '1;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : csl_sync
